/* File: verif/uif_usb_irq_flags_asserts.sv */
`timescale 1ns/1ps
// ----
// Bus and flag checks on top ports
// ----
module uif_usb_irq_flags_asserts (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic BVALID,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic [31:0] RDATA,
   input wire logic [1:0] RRESP,
   input wire logic RVALID,
   input wire logic USB_IRQ
);
   import uif_pkg::*;
   logic [7:0] rd_addr_reg;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // Address of the read in flight, for tying data to its register
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         rd_addr_reg <= 8'h00;
      else if (ARVALID && ARREADY)
         rd_addr_reg <= ARADDR;
   end
   a_write_answer: assert property ((AWVALID && AWREADY && WVALID && WREADY)
      |=> !BVALID ##1 BVALID) else $error("write answer not two cycles after take");
   a_aw_blocked: assert property ((AWVALID && AWREADY) |=> !AWREADY [*2])
      else $error("write address accepted again too early");
   a_ar_blocked: assert property ((ARVALID && ARREADY) |=> !ARREADY && RVALID)
      else $error("read answer missing after take");
   a_read_resp: assert property ((ARVALID && ARREADY)
      |=> RRESP == ((rd_addr_reg > ADDR_CTRL) ? RESP_SLVERR : RESP_OKAY))
      else $error("read response code wrong");
   a_upper_zero: assert property (RVALID |-> RDATA[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   a_unmapped_zero: assert property (RVALID && rd_addr_reg > ADDR_CTRL |-> RDATA == 32'h0)
      else $error("unmapped read not zero");
   a_en_bit_one: assert property (RVALID && rd_addr_reg == ADDR_OTG_EN |-> !RDATA[1])
      else $error("enable bit 1 reads one");
   a_stat_bit_six: assert property (RVALID && rd_addr_reg == ADDR_DEV_STAT |-> !RDATA[6])
      else $error("status bit 6 reads one");
   a_irq_fall_cause: assert property ($fell(USB_IRQ)
      |-> $past(BVALID) || $past(BVALID, 2) || $past(BVALID, 3))
      else $error("interrupt dropped without a write");
endmodule // uif_usb_irq_flags_asserts

bind uif_usb_irq_flags uif_usb_irq_flags_asserts u_chk (.CLK(CLK), .RST_N(RST_N),
   .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID),
   .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
   .RVALID(RVALID), .USB_IRQ(USB_IRQ));

/* File: verif/uif_usb_irq_flags_bench.sv */
`timescale 1ns/1ps
// ----
// Register-level bench
// ----
module uif_usb_irq_flags_bench;
   import uif_pkg::*;
   `define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fail_count++; \
      $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
   typedef struct packed {logic [7:0] addr; logic [31:0] wdata; logic [7:0] rexp;
      logic [1:0] resp;} uif_row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, usb_irq, token_full;
   logic [1:0] bresp, rresp, resp, rr;
   logic [31:0] rdata, rd;
   uif_pins_t pins;
   uif_engine_t engine;
   int fail_count = 0;
   int total_checks = 0;
   int cycles = 0;
   uif_row_t rows[9] = '{'{ADDR_OTG_EN, 32'hffffffff, 8'hfd, RESP_OKAY},
      '{ADDR_OTG_EN, 32'h2, 8'h00, RESP_OKAY}, '{ADDR_DEV_EN, 32'hffffffff, 8'hbf, RESP_OKAY},
      '{ADDR_DEV_EN, 32'h0, 8'h00, RESP_OKAY}, '{ADDR_ERR_EN, 32'hffffff5a, 8'h5a, RESP_OKAY},
      '{ADDR_ERR_EN, 32'h0, 8'h00, RESP_OKAY}, '{ADDR_TOK_STAT, 32'hff, 8'h00, RESP_OKAY},
      '{8'h24, 32'hffffffff, 8'h00, RESP_SLVERR}, '{8'hfc, 32'hff, 8'h00, RESP_SLVERR}};

   always #2 clk = ~clk;

   // Short counts keep the line-state tests brief
   uif_usb_irq_flags #(.LINE_STEADY_CYCLES(20), .TIMER_CYCLES(16), .IDLE_CYCLES(30),
      .TOKEN_DEPTH(4)) DUT (.CLK(clk), .RST_N(rst_n), .PINS(pins), .ENGINE(engine),
      .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf),
      .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
      .RVALID(rvalid), .RREADY(rready), .TOKEN_FULL(token_full), .USB_IRQ(usb_irq));
   uif_usb_peer peer (.CLK(clk), .PINS(pins), .ENGINE(engine));

   // ----
   // Bus tasks
   // ----
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rdd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] ex,
      input string nm);
      rdd(a);
      `CHK(nm, ex, rd[7:0] & m)
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic done(input string nm);
      $display("test %s finished", nm);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Generous against about 3200 cycles of tests
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         end_sim;
      end
   end

   initial
   begin
      cyc(3);
      rst_n <= 1'b1;
      foreach (rows[i])
      begin
         wr(rows[i].addr, rows[i].wdata);
         `CHK("bresp", rows[i].resp, resp)
         rdd(rows[i].addr);
         `CHK("rresp", rows[i].resp, rr)
         `CHK("rdata", {24'h0, rows[i].rexp}, rd)
      end
      done("table");
      for (int i = 0; i < 16; i++)
      begin
         wr(ADDR_OTG_EN, 32'h1 << i);
         rchk(ADDR_OTG_EN, 8'hff, 8'(32'h1 << i) & 8'hfd, "otg enable bit");
      end
      @(posedge clk);
      rst_n <= 1'b0;
      cyc(3);
      rst_n <= 1'b1;
      rchk(ADDR_OTG_EN, 8'hff, 8'h00, "enable after reset");
      `CHK("irq after reset", 1'b0, usb_irq)
      done("reset");
      peer.pulse('{1'b1, 1'b1, 1'b1, 8'h5a, 8'h00});
      peer.pulse('{1'b0, 1'b0, 1'b1, 8'h3c, 8'h00});
      rchk(ADDR_DEV_STAT, 8'h8c, 8'h8c, "engine flags");
      rchk(ADDR_TOK_STAT, 8'hff, 8'h5a, "token head");
      wr(ADDR_DEV_STAT, 32'h0);
      rchk(ADDR_DEV_STAT, 8'h8c, 8'h8c, "zero write keeps");
      wr(ADDR_DEV_STAT, 32'h08);
      rchk(ADDR_DEV_STAT, 8'h8c, 8'h8c, "token still queued");
      rchk(ADDR_TOK_STAT, 8'hff, 8'h3c, "token next");
      wr(ADDR_DEV_STAT, 32'h88);
      rchk(ADDR_DEV_STAT, 8'h8c, 8'h04, "frame flag kept");
      rchk(ADDR_TOK_STAT, 8'hff, 8'h00, "queue empty");
      for (int i = 1; i <= 5; i++)
         peer.pulse('{1'b0, 1'b0, 1'b1, 8'(i), 8'h00});
      `CHK("queue full", 1'b1, token_full)
      rchk(ADDR_TOK_STAT, 8'hff, 8'h01, "full head");
      repeat (4) wr(ADDR_DEV_STAT, 32'h08);
      rchk(ADDR_DEV_STAT, 8'h08, 8'h00, "fifth dropped");
      `CHK("queue not full", 1'b0, token_full)
      done("events");
      wr(ADDR_DEV_EN, 32'h04);
      cyc(2);
      `CHK("irq on", 1'b1, usb_irq)
      wr(ADDR_DEV_STAT, 32'h04);
      cyc(2);
      `CHK("irq off", 1'b0, usb_irq)
      // Frame strobe lands on the edge where the clear acts
      fork
         wr(ADDR_DEV_STAT, 32'h04);
         begin
            @(posedge clk);
            peer.pulse('{1'b0, 1'b1, 1'b0, 8'h00, 8'h00});
         end
      join
      rchk(ADDR_DEV_STAT, 8'h04, 8'h04, "set beats clear");
      wr(ADDR_DEV_EN, 32'h0);
      done("irq");
      wr(ADDR_ERR_EN, 32'h01);
      peer.pulse('{1'b0, 1'b0, 1'b0, 8'h00, 8'h02});
      cyc(2);
      rchk(ADDR_DEV_STAT, 8'h02, 8'h00, "masked error");
      peer.pulse('{1'b0, 1'b0, 1'b0, 8'h00, 8'h01});
      cyc(2);
      rchk(ADDR_DEV_STAT, 8'h02, 8'h02, "error set");
      wr(ADDR_DEV_STAT, 32'h02);
      rchk(ADDR_DEV_STAT, 8'h02, 8'h02, "error read only");
      wr(ADDR_ERR_STAT, 32'hff);
      cyc(2);
      rchk(ADDR_DEV_STAT, 8'h02, 8'h00, "error gone");
      done("error");
      peer.line(1'b0, 1'b1);
      cyc(590);
      rchk(ADDR_DEV_STAT, 8'h20, 8'h00, "resume early");
      cyc(50);
      rchk(ADDR_DEV_STAT, 8'h20, 8'h20, "resume");
      wr(ADDR_DEV_STAT, 32'hff);
      peer.line(1'b1, 1'b0);
      cyc(10);
      rchk(ADDR_DEV_STAT, 8'h10, 8'h00, "idle early");
      cyc(40);
      rchk(ADDR_DEV_STAT, 8'h10, 8'h10, "idle");
      done("resume idle");
      wr(ADDR_DEV_STAT, 32'hff);
      wr(ADDR_CTRL, 32'h1);
      cyc(660);
      rchk(ADDR_DEV_STAT, 8'h20, 8'h20, "low speed resume");
      wr(ADDR_CTRL, 32'h0);
      peer.line(1'b0, 1'b0);
      cyc(660);
      rchk(ADDR_DEV_STAT, 8'h01, 8'h01, "bus reset");
      wr(ADDR_DEV_STAT, 32'h01);
      cyc(50);
      rchk(ADDR_DEV_STAT, 8'h01, 8'h00, "no second set");
      peer.line(1'b1, 1'b0);
      cyc(20);
      peer.line(1'b0, 1'b0);
      cyc(660);
      rchk(ADDR_DEV_STAT, 8'h01, 8'h01, "bus reset again");
      done("bus reset");
      wr(ADDR_OTG_CLR, 32'hff);
      peer.line(1'b1, 1'b0);
      cyc(40);
      rchk(ADDR_OTG_STAT, 8'h20, 8'h20, "line steady");
      wr(ADDR_OTG_CLR, 32'h20);
      cyc(40);
      rchk(ADDR_OTG_STAT, 8'h20, 8'h00, "line unchanged");
      wr(ADDR_OTG_EN, 32'h80);
      wr(ADDR_OTG_CLR, 32'hff);
      cyc(2);
      `CHK("otg irq quiet", 1'b0, usb_irq)
      peer.flip_id;
      cyc(10);
      `CHK("id change irq", 1'b1, usb_irq)
      wr(ADDR_OTG_EN, 32'h0);
      cyc(2);
      `CHK("otg irq masked", 1'b0, usb_irq)
      done("otg");
      end_sim;
   end
endmodule // uif_usb_irq_flags_bench

/* File: verif/uif_usb_peer.sv */
`timescale 1ns/1ps
// ----
// USB bus side and engine stand-in
// ----
module uif_usb_peer (
   input wire logic CLK,
   output uif_pkg::uif_pins_t PINS,
   output uif_pkg::uif_engine_t ENGINE
);
   import uif_pkg::*;
   // Start in full-speed J so the line is idle
   initial
   begin
      PINS = 6'b000010;
      ENGINE = '0;
   end
   // Full speed: K is dm high, SE0 both low
   task automatic line(input logic dp, input logic dm);
      @(posedge CLK);
      PINS.dp <= dp;
      PINS.dm <= dm;
   endtask
   task automatic flip_id;
      @(posedge CLK);
      PINS.id <= ~PINS.id;
   endtask
   // Engine strobes last exactly one cycle
   task automatic pulse(input uif_engine_t e);
      @(posedge CLK);
      ENGINE <= e;
      @(posedge CLK);
      ENGINE <= '0;
   endtask
endmodule // uif_usb_peer

/* File: verilog/uif_pkg.sv */
package uif_pkg;
   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_OTG_STAT = 8'h00;
   localparam logic [7:0] ADDR_OTG_EN = 8'h04;
   localparam logic [7:0] ADDR_OTG_CLR = 8'h08;
   localparam logic [7:0] ADDR_DEV_STAT = 8'h0c;
   localparam logic [7:0] ADDR_DEV_EN = 8'h10;
   localparam logic [7:0] ADDR_ERR_STAT = 8'h14;
   localparam logic [7:0] ADDR_ERR_EN = 8'h18;
   localparam logic [7:0] ADDR_TOK_STAT = 8'h1c;
   localparam logic [7:0] ADDR_CTRL = 8'h20;
   // ----------------------------------------------------------------
   // Field positions and masks
   // ----------------------------------------------------------------
   localparam int OTG_ID = 7;
   localparam int OTG_TMR = 6;
   localparam int OTG_LINE = 5;
   localparam int OTG_ACT = 4;
   localparam int OTG_SESV = 3;
   localparam int OTG_SESEND = 2;
   localparam int OTG_VBUS = 0;
   localparam int DEV_STALL = 7;
   localparam int DEV_RESUME = 5;
   localparam int DEV_IDLE = 4;
   localparam int DEV_TOKEN = 3;
   localparam int DEV_SOF = 2;
   localparam int DEV_ERR = 1;
   localparam int DEV_URST = 0;
   localparam int CTRL_LOW_SPEED = 0;
   localparam logic [7:0] OTG_IMPL_MASK = 8'hfd;
   localparam logic [7:0] DEV_IMPL_MASK = 8'hbf;
   localparam logic [7:0] DEV_W1C_MASK = 8'hb5;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int KSTATE_TIME_NS = 2500;
   localparam int RESET_TIME_NS = 2500;
   localparam int LINE_STEADY_TIME_US = 1000;
   localparam int TIMER_TIME_US = 1000;
   localparam int IDLE_TIME_US = 3000;
   localparam int KSTATE_CYC = (KSTATE_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int RESET_CYC = (RESET_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int LINE_STEADY_CYC = LINE_STEADY_TIME_US * CLK_MHZ;
   localparam int TIMER_CYC = TIMER_TIME_US * CLK_MHZ;
   localparam int IDLE_CYC = IDLE_TIME_US * CLK_MHZ;
   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic id;
      logic sess_valid;
      logic b_sess_end;
      logic a_vbus_valid;
      logic dp;
      logic dm;
   } uif_pins_t;
   typedef struct packed {
      logic stall_sent;
      logic sof;
      logic token_done;
      logic [7:0] token_info;
      logic [7:0] errors;
   } uif_engine_t;
endpackage

/* File: verilog/uif_usb_irq_flags.sv */
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
// Function
// - Each implemented OTG enable bit lets its OTG flag raise interrupt; resets to 0.
// - Bits 15-8 of both registers ignore writes and read zero.
// - Enable bits: ID change 7, 1 ms timer 6, line steady 5, activity 4.
// - Enable bits: session valid 3, session end 2, VBUS valid 0; bit 1 zero.
// - Device flags other than error bit 1 set by hardware, cleared only by writing 1; 0 keeps.
// - Bit 7 sets on STALL handshake sent; bit 6 reads zero.
// - Resume flag bit 5 sets after K-state lasts 2.5 us.
// - Idle flag bit 4 sets after 3 ms of continuous idle.
// - Token flag bit 3 sets when token done; its status is readable.
// - Clearing token flag advances token status queue to next entry.
// - Frame start flag bit 2 sets on start-of-frame token.
// - Error flag bit 1 read-only, set only by enabled error conditions.
// - Bus reset flag bit 0 sets after reset persists 2.5 us.
// - Bus reset flag cannot set again until bus leaves reset.
// - Line steady event when line held 1 ms and differs from recorded.
// - ID change event on any detected change of ID pin.
module uif_usb_irq_flags #(
   parameter int LINE_STEADY_CYCLES = uif_pkg::LINE_STEADY_CYC,
   parameter int TIMER_CYCLES = uif_pkg::TIMER_CYC,
   parameter int IDLE_CYCLES = uif_pkg::IDLE_CYC,
   parameter int TOKEN_DEPTH = 4
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire uif_pkg::uif_pins_t PINS,
   input wire uif_pkg::uif_engine_t ENGINE,
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   output logic TOKEN_FULL,
   output logic USB_IRQ
);
   import uif_pkg::*;

   localparam int MK = (KSTATE_CYC > RESET_CYC) ? KSTATE_CYC : RESET_CYC;
   localparam int MA = (IDLE_CYCLES > LINE_STEADY_CYCLES) ? IDLE_CYCLES : LINE_STEADY_CYCLES;
   localparam int MB = (TIMER_CYCLES > MK) ? TIMER_CYCLES : MK;
   localparam int CW = $clog2(((MA > MB) ? MA : MB) + 1);
   localparam int PW = $clog2(TOKEN_DEPTH);
   localparam logic [CW-1:0] K_LIM = CW'(KSTATE_CYC);
   localparam logic [CW-1:0] R_LIM = CW'(RESET_CYC);
   localparam logic [CW-1:0] L_LIM = CW'(LINE_STEADY_CYCLES);
   localparam logic [CW-1:0] T_LIM = CW'(TIMER_CYCLES);
   localparam logic [CW-1:0] I_LIM = CW'(IDLE_CYCLES);
   localparam logic [PW:0] T_DEPTH = (PW + 1)'(TOKEN_DEPTH);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [5:0] s1_reg, s2_reg, s3_reg, pin_reg, prev_reg;
   logic [4:0] fill_reg;
   logic primed;
   uif_pins_t pins, prev;
   assign pins = pin_reg;
   assign primed = fill_reg[4];
   // Filter resets to 0, not to the pin level: hide that first step
   assign prev = primed ? prev_reg : pin_reg;

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         s1_reg <= 6'h00;
         s2_reg <= 6'h00;
         s3_reg <= 6'h00;
         pin_reg <= 6'h00;
         prev_reg <= 6'h00;
         fill_reg <= 5'h00;
      end
      else
      begin
         s1_reg <= PINS;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         // Only a level seen by both later stages is taken
         pin_reg <= (s2_reg & s3_reg) | (pin_reg & (s2_reg ^ s3_reg));
         prev_reg <= pin_reg;
         fill_reg <= {fill_reg[3:0], 1'b1};
      end
   end

   // ----------------------------------------------------------------
   // Line state decode
   // ----------------------------------------------------------------
   logic [7:0] ctrl_reg;
   logic low_speed, se0, k_state, idle_state, line_moved;
   assign low_speed = ctrl_reg[CTRL_LOW_SPEED];
   assign se0 = !pins.dp && !pins.dm;
   assign k_state = low_speed ? (pins.dp && !pins.dm) : (!pins.dp && pins.dm);
   assign idle_state = low_speed ? (!pins.dp && pins.dm) : (pins.dp && !pins.dm);
   assign line_moved = (pins.dp != prev.dp) || (pins.dm != prev.dm);

   // ----------------------------------------------------------------
   // Duration counters
   // ----------------------------------------------------------------
   logic [CW-1:0] k_cnt_reg, r_cnt_reg, i_cnt_reg, l_cnt_reg, t_cnt_reg;
   logic [1:0] line_rec_reg;
   logic resume_evt, reset_evt, idle_evt, line_evt, timer_evt;

   assign resume_evt = k_state && (k_cnt_reg == K_LIM - 1'b1);
   // Saturating count fires once per reset episode
   assign reset_evt = se0 && (r_cnt_reg == R_LIM - 1'b1);
   assign idle_evt = idle_state && (i_cnt_reg == I_LIM - 1'b1);
   assign line_evt = !line_moved && (l_cnt_reg == L_LIM - 1'b1)
                     && ({pins.dp, pins.dm} != line_rec_reg);
   assign timer_evt = (t_cnt_reg == T_LIM - 1'b1);

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         k_cnt_reg <= '0;
         r_cnt_reg <= '0;
         i_cnt_reg <= '0;
      end
      else
      begin
         if (!k_state)
            k_cnt_reg <= '0;
         else if (k_cnt_reg != K_LIM)
            k_cnt_reg <= k_cnt_reg + 1'b1;
         if (!se0)
            r_cnt_reg <= '0;
         else if (r_cnt_reg != R_LIM)
            r_cnt_reg <= r_cnt_reg + 1'b1;
         if (!idle_state)
            i_cnt_reg <= '0;
         else if (i_cnt_reg != I_LIM)
            i_cnt_reg <= i_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         l_cnt_reg <= '0;
         line_rec_reg <= 2'h0;
         t_cnt_reg <= '0;
      end
      else
      begin
         if (line_moved)
            l_cnt_reg <= '0;
         else if (l_cnt_reg != L_LIM)
            l_cnt_reg <= l_cnt_reg + 1'b1;
         if (line_evt)
            line_rec_reg <= {pins.dp, pins.dm};
         t_cnt_reg <= timer_evt ? '0 : t_cnt_reg + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg, rdata_reg;
   logic [3:0] wstrb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic wr_fire, wr_lane;
   logic [7:0] wbyte;

   assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
   // Upper bytes carry nothing, so only lane 0 acts
   assign wr_lane = wr_fire && wstrb_reg[0];
   assign wbyte = wdata_reg[7:0];

   function automatic logic mapped(input logic [7:0] a);
      return a[7:2] <= ADDR_CTRL[7:2];
   endfunction

   function automatic logic hit_at(input logic [7:0] a, input logic [7:0] r);
      return wr_lane && (a[7:2] == r[7:2]);
   endfunction

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         bresp_reg <= RESP_OKAY;
      end
      else
      begin
         if (AWVALID && awready_reg)
         begin
            awaddr_reg <= AWADDR;
            awready_reg <= 1'b0;
         end
         if (WVALID && wready_reg)
         begin
            wdata_reg <= WDATA;
            wstrb_reg <= WSTRB;
            wready_reg <= 1'b0;
         end
         if (wr_fire)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg <= mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bvalid_reg && BREADY)
         begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Software controlled registers
   // ----------------------------------------------------------------
   logic [7:0] otg_en_reg, dev_en_reg, err_en_reg;

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         otg_en_reg <= REG_RESET;
         dev_en_reg <= REG_RESET;
         err_en_reg <= REG_RESET;
         ctrl_reg <= REG_RESET;
      end
      else
      begin
         if (hit_at(awaddr_reg, ADDR_OTG_EN))
            otg_en_reg <= wbyte & OTG_IMPL_MASK;
         if (hit_at(awaddr_reg, ADDR_DEV_EN))
            dev_en_reg <= wbyte & DEV_IMPL_MASK;
         if (hit_at(awaddr_reg, ADDR_ERR_EN))
            err_en_reg <= wbyte;
         if (hit_at(awaddr_reg, ADDR_CTRL))
            ctrl_reg <= wbyte & 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // Token status queue
   // ----------------------------------------------------------------
   logic [7:0] tok_mem [TOKEN_DEPTH];
   logic [PW-1:0] tok_wr_reg, tok_rd_reg;
   logic [PW:0] tok_cnt_reg, tok_cnt_next;
   logic tok_push, tok_pop;

   assign tok_push = ENGINE.token_done && (tok_cnt_reg != T_DEPTH);
   // Writing 1 to the token flag retires the presented entry
   assign tok_pop = hit_at(awaddr_reg, ADDR_DEV_STAT) && wbyte[DEV_TOKEN]
                    && (tok_cnt_reg != '0);
   assign tok_cnt_next = tok_cnt_reg + (PW + 1)'(tok_push) - (PW + 1)'(tok_pop);

   always_ff @(posedge CLK)
   begin
      if (tok_push)
         tok_mem[tok_wr_reg] <= ENGINE.token_info;
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         tok_wr_reg <= '0;
         tok_rd_reg <= '0;
         tok_cnt_reg <= '0;
      end
      else
      begin
         if (tok_push)
            tok_wr_reg <= (tok_wr_reg == PW'(TOKEN_DEPTH - 1)) ? '0 : tok_wr_reg + 1'b1;
         if (tok_pop)
            tok_rd_reg <= (tok_rd_reg == PW'(TOKEN_DEPTH - 1)) ? '0 : tok_rd_reg + 1'b1;
         tok_cnt_reg <= tok_cnt_next;
      end
   end

   // ----------------------------------------------------------------
   // Event flags
   // ----------------------------------------------------------------
   logic [7:0] otg_stat_reg, dev_flag_reg, err_stat_reg;
   logic tok_flag_reg, err_sum_reg;
   logic [7:0] otg_set, dev_set, otg_clr, dev_clr, err_clr, dev_view;

   always_comb
   begin
      otg_set = 8'h00;
      otg_set[OTG_ID] = pins.id != prev.id;
      otg_set[OTG_TMR] = timer_evt;
      otg_set[OTG_LINE] = line_evt;
      otg_set[OTG_ACT] = pins != prev;
      otg_set[OTG_SESV] = pins.sess_valid != prev.sess_valid;
      otg_set[OTG_SESEND] = pins.b_sess_end != prev.b_sess_end;
      otg_set[OTG_VBUS] = pins.a_vbus_valid != prev.a_vbus_valid;
      dev_set = 8'h00;
      dev_set[DEV_STALL] = ENGINE.stall_sent;
      dev_set[DEV_RESUME] = resume_evt;
      dev_set[DEV_IDLE] = idle_evt;
      dev_set[DEV_SOF] = ENGINE.sof;
      dev_set[DEV_URST] = reset_evt;
   end

   assign otg_clr = hit_at(awaddr_reg, ADDR_OTG_CLR) ? wbyte & OTG_IMPL_MASK : 8'h00;
   // Zero bits leave flags alone, so a whole-word write clears selectively
   assign dev_clr = hit_at(awaddr_reg, ADDR_DEV_STAT) ? wbyte & DEV_W1C_MASK : 8'h00;
   assign err_clr = hit_at(awaddr_reg, ADDR_ERR_STAT) ? wbyte : 8'h00;

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         otg_stat_reg <= REG_RESET;
         dev_flag_reg <= REG_RESET;
         err_stat_reg <= REG_RESET;
         tok_flag_reg <= 1'b0;
         err_sum_reg <= 1'b0;
      end
      else
      begin
         otg_stat_reg <= (otg_stat_reg & ~otg_clr) | otg_set;
         dev_flag_reg <= (dev_flag_reg & ~dev_clr) | dev_set;
         err_stat_reg <= (err_stat_reg & ~err_clr) | ENGINE.errors;
         // Stays set while further entries wait behind the retired one
         tok_flag_reg <= tok_cnt_next != '0;
         err_sum_reg <= |(err_stat_reg & err_en_reg);
      end
   end

   always_comb
   begin
      dev_view = dev_flag_reg & DEV_W1C_MASK;
      dev_view[DEV_TOKEN] = tok_flag_reg;
      dev_view[DEV_ERR] = err_sum_reg;
   end

   // ----------------------------------------------------------------
   // Read path and interrupt
   // ----------------------------------------------------------------
   logic [7:0] rbyte;
   logic irq_reg, full_reg;

   always_comb
   begin
      rbyte = 8'h00;
      unique case (ARADDR[7:2])
         ADDR_OTG_STAT[7:2]: rbyte = otg_stat_reg;
         ADDR_OTG_EN[7:2]: rbyte = otg_en_reg;
         ADDR_DEV_STAT[7:2]: rbyte = dev_view;
         ADDR_DEV_EN[7:2]: rbyte = dev_en_reg;
         ADDR_ERR_STAT[7:2]: rbyte = err_stat_reg;
         ADDR_ERR_EN[7:2]: rbyte = err_en_reg;
         ADDR_TOK_STAT[7:2]: rbyte = (tok_cnt_reg != '0) ? tok_mem[tok_rd_reg] : 8'h00;
         ADDR_CTRL[7:2]: rbyte = ctrl_reg;
         default: rbyte = 8'h00;
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= RESP_OKAY;
      end
      else if (ARVALID && arready_reg)
      begin
         rdata_reg <= {24'h0, rbyte};
         rresp_reg <= mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
         rvalid_reg <= 1'b1;
         arready_reg <= 1'b0;
      end
      else if (rvalid_reg && RREADY)
      begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         irq_reg <= 1'b0;
         full_reg <= 1'b0;
      end
      else
      begin
         irq_reg <= |(otg_stat_reg & otg_en_reg) || |(dev_view & dev_en_reg);
         full_reg <= tok_cnt_next == T_DEPTH;
      end
   end

   assign AWREADY = awready_reg;
   assign WREADY = wready_reg;
   assign BVALID = bvalid_reg;
   assign BRESP = bresp_reg;
   assign ARREADY = arready_reg;
   assign RVALID = rvalid_reg;
   assign RDATA = rdata_reg;
   assign RRESP = rresp_reg;
   assign TOKEN_FULL = full_reg;
   assign USB_IRQ = irq_reg;
endmodule // uif_usb_irq_flags
